// >>> design/swbl_pkg.sv
package swbl_pkg;
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DEBOUNCE_US    = 1000;
  localparam int DEBOUNCE_CYC   = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_HZ         = 32768;
  localparam int OVERRIDE_S     = 4;
  localparam int OVERRIDE_TICKS = REF_HZ * OVERRIDE_S;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATE   = 8'h0c;

  // Status bits, write one to clear
  localparam int ST_PWR = 0;
  localparam int ST_SLP = 1;
  localparam int ST_WAK = 2;
  localparam int ST_ALM = 3;
  localparam int ST_OVR = 4;
  // Enable bits
  localparam int EN_PWR = 0;
  localparam int EN_SLP = 1;
  localparam int EN_ALM = 2;
  localparam logic [2:0] ENABLE_RST = 3'h0;
  // Control fields
  localparam int CTL_KIND_LSB = 0;
  localparam int CTL_GO       = 3;
  // State register fields
  localparam int STA_KIND_LSB = 0;
  localparam int STA_ASLEEP   = 3;
  localparam int STA_CAP      = 4;
  localparam int STA_SEQ_LSB  = 5;

  typedef logic [2:0] swbl_kind_t;
  localparam swbl_kind_t KIND_S1  = 3'h1;
  localparam swbl_kind_t KIND_S2  = 3'h2;
  localparam swbl_kind_t KIND_S3  = 3'h3;
  localparam swbl_kind_t KIND_S4  = 3'h4;
  localparam swbl_kind_t KIND_S5  = 3'h5;
  localparam swbl_kind_t KIND_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic power_button;
    logic sleep_button;
    logic alarm_irq;
    logic battery_low;
    logic ref_clk;
  } swbl_pins_t;

  typedef struct packed {
    logic       asleep;
    swbl_kind_t kind;
    logic       cpu_reset;
    logic       resume;
  } swbl_pwr_t;

  typedef enum logic [1:0] {SEQ_WORK, SEQ_ENTER, SEQ_SLEEP, SEQ_WAKE} swbl_seq_t;
endpackage

// >>> design/swbl_debounce.sv
module swbl_debounce #(
  parameter int unsigned CYC = 4
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Raw button and cleaned result
  input  wire logic raw,
  output logic      level,
  output logic      press
);
  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt_r;
  logic         level_r;
  logic         press_r;
  wire          differs = raw != level_r;
  wire          settle  = differs && (cnt_r == LAST);

  assign level = level_r;
  assign press = press_r;

  // Level must differ for CYC cycles in a row before it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
      press_r <= 1'b0;
    end else begin
      cnt_r   <= (differs && !settle) ? cnt_r + 1'b1 : '0;
      level_r <= settle ? raw : level_r;
      press_r <= settle && raw;
    end
  end
endmodule

// >>> design/swbl_top.sv
// Functional notes
// - Power button held over four seconds in working state forces soft-off.
// - Override event clears the power button press flag.
// - Override enters the sequencer directly, forcing off regardless of software.
// - Sleep button press sets sticky sleep flag until software clears it.
// - Interrupt when sleep flag set by working-state press and its enable set.
// - Sleep button debounced; flag set once on the press edge.
// - Further sleep press while sleeping sets flag and wakes if enabled.
// - Sleep go sequences system into state chosen by sleep kind, S1-S5.
// - Once processor stopped, enabled wake event sets wake flag and wakes.
// - Without S1 support the wake flag may read as zero.
// - Wake from S1 resumes directly; S2-S5 wake restarts processor at reset.
// - Changing state needs waking, new sleep kind, then sleep go again.
// - Alarm wake works in S1 through S3.
// - Alarm wake from S4 optional, shown by a capability flag.
// - Alarm sets alarm flag; with its enable it wakes a sleeping system.
// - Alarm wake blocked while battery-low is asserted.
// - Alarm flag set from the clock chip interrupt pin.
// - Power press sets flag; interrupt if enabled and press in working state.
// - Power press while sleeping sets flag and wakes, regardless of enable.
module swbl_top #(
  parameter int unsigned DEBOUNCE_CYC   = swbl_pkg::DEBOUNCE_CYC,
  parameter int unsigned OVERRIDE_TICKS = swbl_pkg::OVERRIDE_TICKS,
  parameter bit          SUPPORT_S1     = 1'b1,
  parameter bit          ALARM_S4_CAP   = 1'b0
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]          s_axil_awaddr,
  input  wire logic                s_axil_awvalid,
  output logic                     s_axil_awready,
  input  wire logic [31:0]         s_axil_wdata,
  input  wire logic [3:0]          s_axil_wstrb,
  input  wire logic                s_axil_wvalid,
  output logic                     s_axil_wready,
  output logic [1:0]               s_axil_bresp,
  output logic                     s_axil_bvalid,
  input  wire logic                s_axil_bready,
  // AXI4-Lite read
  input  wire logic [7:0]          s_axil_araddr,
  input  wire logic                s_axil_arvalid,
  output logic                     s_axil_arready,
  output logic [31:0]              s_axil_rdata,
  output logic [1:0]               s_axil_rresp,
  output logic                     s_axil_rvalid,
  input  wire logic                s_axil_rready,
  // Buttons, alarm pin, battery, reference
  input  wire swbl_pkg::swbl_pins_t pins,
  // Platform power control and interrupt
  output swbl_pkg::swbl_pwr_t      pwr,
  output logic                     system_control_irq
);
  localparam int OW = $clog2(OVERRIDE_TICKS + 1);
  localparam logic [OW-1:0] OVR_LAST = OW'(OVERRIDE_TICKS - 1);
  localparam logic [OW-1:0] OVR_FULL = OW'(OVERRIDE_TICKS);

  // Bus side state
  logic                 awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]           bresp_r, rresp_r;
  logic [31:0]          rdata_r, wdata_r;
  logic [7:0]           awaddr_r;
  logic                 wstrb0_r;
  // Block state
  logic                 pwr_flag_r, slp_flag_r, wak_flag_r, alm_flag_r, ovr_flag_r;
  logic [2:0]           enable_r;
  swbl_pkg::swbl_kind_t ctl_kind_r, kind_r;
  swbl_pkg::swbl_seq_t  seq_r, seq_nxt;
  logic [OW-1:0]        ovr_cnt_r;
  logic                 ref_q_r, alarm_q_r;
  logic                 irq_r, asleep_r, cpu_reset_r, resume_r;

  // Debounced buttons
  logic pwr_level, pwr_press, slp_level, slp_press;

  swbl_debounce #(.CYC(DEBOUNCE_CYC)) u_pwr_db (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (pins.power_button),
    .level   (pwr_level),
    .press   (pwr_press)
  );

  swbl_debounce #(.CYC(DEBOUNCE_CYC)) u_slp_db (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (pins.sleep_button),
    .level   (slp_level),
    .press   (slp_press)
  );

  // Bus decode
  wire aw_hs   = s_axil_awvalid && awready_r;
  wire w_hs    = s_axil_wvalid && wready_r;
  wire wr_do   = !awready_r && !wready_r && !bvalid_r;
  wire wr_ok   = (awaddr_r == swbl_pkg::ADDR_STATUS) || (awaddr_r == swbl_pkg::ADDR_ENABLE) ||
                 (awaddr_r == swbl_pkg::ADDR_CONTROL) || (awaddr_r == swbl_pkg::ADDR_STATE);
  wire wr_b0   = wr_do && wstrb0_r;
  wire wr_st   = wr_b0 && (awaddr_r == swbl_pkg::ADDR_STATUS);
  wire wr_en   = wr_b0 && (awaddr_r == swbl_pkg::ADDR_ENABLE);
  wire wr_ctl  = wr_b0 && (awaddr_r == swbl_pkg::ADDR_CONTROL);
  wire ar_hs   = s_axil_arvalid && arready_r;
  wire r_hs    = rvalid_r && s_axil_rready;
  wire b_hs    = bvalid_r && s_axil_bready;

  // Write-one-to-clear strobes
  wire clr_pwr = wr_st && wdata_r[swbl_pkg::ST_PWR];
  wire clr_slp = wr_st && wdata_r[swbl_pkg::ST_SLP];
  wire clr_wak = wr_st && wdata_r[swbl_pkg::ST_WAK];
  wire clr_alm = wr_st && wdata_r[swbl_pkg::ST_ALM];
  wire clr_ovr = wr_st && wdata_r[swbl_pkg::ST_OVR];

  // Sleep request
  wire swbl_pkg::swbl_kind_t go_kind = wdata_r[swbl_pkg::CTL_KIND_LSB +: 3];
  wire kind_valid = (go_kind >= swbl_pkg::KIND_S1) && (go_kind <= swbl_pkg::KIND_S5);
  wire go_req     = wr_ctl && wdata_r[swbl_pkg::CTL_GO] && kind_valid;

  // Override hold measured on the reference clock
  wire ref_tick   = pins.ref_clk && !ref_q_r;
  wire in_work    = seq_r == swbl_pkg::SEQ_WORK;
  wire in_sleep   = seq_r == swbl_pkg::SEQ_SLEEP;
  wire ovr_fire   = in_work && pwr_level && ref_tick && (ovr_cnt_r == OVR_LAST);

  // Alarm
  wire alarm_edge = pins.alarm_irq && !alarm_q_r;
  wire alm_state  = (kind_r >= swbl_pkg::KIND_S1 && kind_r <= swbl_pkg::KIND_S3) ||
                    (ALARM_S4_CAP && kind_r == swbl_pkg::KIND_S4);
  wire alm_wake   = alm_flag_r && enable_r[swbl_pkg::EN_ALM] && !pins.battery_low && alm_state;

  // Wake sources, only once the processor has stopped
  wire slp_wake   = slp_press && enable_r[swbl_pkg::EN_SLP];
  wire wake_ev    = in_sleep && (pwr_press || slp_wake || alm_wake);
  wire deep       = kind_r != swbl_pkg::KIND_S1;

  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      swbl_pkg::SEQ_WORK: begin
        if (ovr_fire || go_req) begin
          seq_nxt = swbl_pkg::SEQ_ENTER;
        end
      end
      swbl_pkg::SEQ_ENTER: seq_nxt = swbl_pkg::SEQ_SLEEP;
      swbl_pkg::SEQ_SLEEP: begin
        if (wake_ev) begin
          seq_nxt = swbl_pkg::SEQ_WAKE;
        end
      end
      swbl_pkg::SEQ_WAKE: seq_nxt = swbl_pkg::SEQ_WORK;
    endcase
  end

  // Sequencer and power outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r       <= swbl_pkg::SEQ_WORK;
      kind_r      <= swbl_pkg::KIND_RST;
      asleep_r    <= 1'b0;
      cpu_reset_r <= 1'b0;
      resume_r    <= 1'b0;
    end else begin
      seq_r       <= seq_nxt;
      if (in_work && ovr_fire) begin
        kind_r <= swbl_pkg::KIND_S5;
      end else if (in_work && go_req) begin
        kind_r <= go_kind;
      end
      asleep_r    <= seq_nxt == swbl_pkg::SEQ_ENTER || seq_nxt == swbl_pkg::SEQ_SLEEP;
      cpu_reset_r <= seq_r == swbl_pkg::SEQ_WAKE && deep;
      resume_r    <= seq_r == swbl_pkg::SEQ_WAKE && !deep;
    end
  end

  // Override counter restarts whenever the button is let go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_cnt_r <= '0;
      ref_q_r   <= 1'b0;
      alarm_q_r <= 1'b0;
    end else begin
      ref_q_r   <= pins.ref_clk;
      alarm_q_r <= pins.alarm_irq;
      if (!pwr_level) begin
        ovr_cnt_r <= '0;
      end else if (ref_tick && ovr_cnt_r != OVR_FULL) begin
        ovr_cnt_r <= ovr_cnt_r + 1'b1;
      end
    end
  end

  // Status flags: a set in the same cycle as a clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_flag_r <= 1'b0;
      slp_flag_r <= 1'b0;
      wak_flag_r <= 1'b0;
      alm_flag_r <= 1'b0;
      ovr_flag_r <= 1'b0;
    end else begin
      pwr_flag_r <= !ovr_fire && (pwr_press || (pwr_flag_r && !clr_pwr));
      slp_flag_r <= slp_press || (slp_flag_r && !clr_slp);
      wak_flag_r <= SUPPORT_S1 && (wake_ev || (wak_flag_r && !clr_wak));
      alm_flag_r <= alarm_edge || (alm_flag_r && !clr_alm);
      ovr_flag_r <= ovr_fire || (ovr_flag_r && !clr_ovr);
    end
  end

  // Software-facing control bits and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r   <= swbl_pkg::ENABLE_RST;
      ctl_kind_r <= swbl_pkg::KIND_RST;
      irq_r      <= 1'b0;
    end else begin
      if (wr_en) begin
        enable_r <= wdata_r[2:0];
      end
      if (wr_ctl) begin
        ctl_kind_r <= go_kind;
      end
      irq_r <= in_work && ((pwr_flag_r && enable_r[swbl_pkg::EN_PWR]) ||
                           (slp_flag_r && enable_r[swbl_pkg::EN_SLP]));
    end
  end

  // Read mux
  wire [4:0] status_v = {ovr_flag_r, alm_flag_r, wak_flag_r, slp_flag_r, pwr_flag_r};
  wire [6:0] state_v  = {seq_r, ALARM_S4_CAP, asleep_r, kind_r};
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    unique case (s_axil_araddr)
      swbl_pkg::ADDR_STATUS:  rd_mux = {27'h0, status_v};
      swbl_pkg::ADDR_ENABLE:  rd_mux = {29'h0, enable_r};
      swbl_pkg::ADDR_CONTROL: rd_mux = {29'h0, ctl_kind_r};
      swbl_pkg::ADDR_STATE:   rd_mux = {25'h0, state_v};
      default:                rd_ok  = 1'b0;
    endcase
  end

  // AXI4-Lite slave: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= swbl_pkg::RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (aw_hs) begin
        awaddr_r  <= s_axil_awaddr;
        awready_r <= 1'b0;
      end
      if (w_hs) begin
        wdata_r  <= s_axil_wdata;
        wstrb0_r <= s_axil_wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? swbl_pkg::RESP_OKAY : swbl_pkg::RESP_SLVERR;
      end
      if (b_hs) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= swbl_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_ok ? swbl_pkg::RESP_OKAY : swbl_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign s_axil_awready     = awready_r;
  assign s_axil_wready      = wready_r;
  assign s_axil_bvalid      = bvalid_r;
  assign s_axil_bresp       = bresp_r;
  assign s_axil_arready     = arready_r;
  assign s_axil_rvalid      = rvalid_r;
  assign s_axil_rdata       = rdata_r;
  assign s_axil_rresp       = rresp_r;
  assign system_control_irq = irq_r;
  assign pwr.asleep         = asleep_r;
  assign pwr.kind           = kind_r;
  assign pwr.cpu_reset      = cpu_reset_r;
  assign pwr.resume         = resume_r;

  property p_ovr_off;
    @(posedge aclk) disable iff (!aresetn)
    ovr_fire |=> seq_r == swbl_pkg::SEQ_ENTER ##1 (seq_r == swbl_pkg::SEQ_SLEEP && kind_r == swbl_pkg::KIND_S5);
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("override did not force off");
  property p_ovr_clr;
    @(posedge aclk) disable iff (!aresetn)
    ovr_fire |=> !pwr_flag_r && ovr_flag_r;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("override left power flag set");
  property p_slp_set;
    @(posedge aclk) disable iff (!aresetn)
    slp_press |=> slp_flag_r;
  endproperty
  a_slp_set: assert property (p_slp_set) else $error("sleep press lost");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    (in_work && slp_flag_r && enable_r[swbl_pkg::EN_SLP]) |=> system_control_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing interrupt");
  property p_slp_wake;
    @(posedge aclk) disable iff (!aresetn)
    (in_sleep && slp_wake) |=> seq_r == swbl_pkg::SEQ_WAKE ##1 seq_r == swbl_pkg::SEQ_WORK;
  endproperty
  a_slp_wake: assert property (p_slp_wake) else $error("sleep press did not wake");
  property p_go;
    @(posedge aclk) disable iff (!aresetn)
    (in_work && go_req && !ovr_fire) |=> (kind_r == $past(go_kind)) ##1 pwr.asleep;
  endproperty
  a_go: assert property (p_go) else $error("sleep request not sequenced");

  property p_pwr_wake;
    @(posedge aclk) disable iff (!aresetn)
    (in_sleep && pwr_press) |=> (pwr_flag_r && (wak_flag_r || !SUPPORT_S1));
  endproperty
  a_pwr_wake: assert property (p_pwr_wake) else $error("power press did not wake");

  property p_batt;
    @(posedge aclk) disable iff (!aresetn)
    (in_sleep && pins.battery_low && !pwr_press && !slp_wake) |=> seq_r != swbl_pkg::SEQ_WAKE;
  endproperty
  a_batt: assert property (p_batt) else $error("alarm woke on low battery");

  property p_reset_vec;
    @(posedge aclk) disable iff (!aresetn)
    (seq_r == swbl_pkg::SEQ_WAKE) |=> (pwr.cpu_reset == (kind_r != swbl_pkg::KIND_S1)) && (pwr.resume != pwr.cpu_reset);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("wrong wake restart");

  property p_alarm;
    @(posedge aclk) disable iff (!aresetn)
    $rose(pins.alarm_irq) |=> alm_flag_r;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pin did not set flag");
endmodule

// >>> tb/swbl_far_model.sv
module swbl_far_model (
  // Clock
  input  wire logic            aclk,
  // Pins toward the block
  output swbl_pkg::swbl_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_r = 2'h0;
  logic       pwr_b = 1'b0;
  logic       slp_b = 1'b0;
  logic       alm   = 1'b0;
  logic       batt  = 1'b0;

  // Reference runs always, one tick every four cycles
  always @(posedge aclk) begin
    div_r <= div_r + 2'h1;
  end

  assign pins = '{power_button: pwr_b, sleep_button: slp_b, alarm_irq: alm, battery_low: batt, ref_clk: div_r[1]};

  // Button 0 power, 1 sleep; release then settle past debounce
  task automatic press(input int btn, input int n);
    @(posedge aclk);
    if (btn == 0) pwr_b <= 1'b1;
    else slp_b <= 1'b1;
    repeat (n) @(posedge aclk);
    pwr_b <= 1'b0;
    slp_b <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask

  // Only the alarm ever drives the interrupt pin
  task automatic alarm_pulse;
    @(posedge aclk);
    alm <= 1'b1;
    repeat (2) @(posedge aclk);
    alm <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic set_batt(input logic v);
    @(posedge aclk);
    batt <= v;
  endtask
endmodule

// >>> tb/tb_sleep_wake_button_logic.sv
module tb_sleep_wake_button_logic;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ST  = swbl_pkg::ADDR_STATUS;
  localparam logic [7:0] EN  = swbl_pkg::ADDR_ENABLE;
  localparam logic [7:0] CTL = swbl_pkg::ADDR_CONTROL;
  localparam logic [7:0] STA = swbl_pkg::ADDR_STATE;

  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic [7:0]           s_axil_awaddr = 8'h00;
  logic                 s_axil_awvalid = 1'b0;
  logic                 s_axil_awready;
  logic [31:0]          s_axil_wdata = 32'h0;
  logic [3:0]           s_axil_wstrb = 4'hf;
  logic                 s_axil_wvalid = 1'b0;
  logic                 s_axil_wready;
  logic [1:0]           s_axil_bresp;
  logic                 s_axil_bvalid;
  logic                 s_axil_bready = 1'b0;
  logic [7:0]           s_axil_araddr = 8'h00;
  logic                 s_axil_arvalid = 1'b0;
  logic                 s_axil_arready;
  logic [31:0]          s_axil_rdata;
  logic [1:0]           s_axil_rresp;
  logic                 s_axil_rvalid;
  logic                 s_axil_rready = 1'b0;
  swbl_pkg::swbl_pins_t pins;
  swbl_pkg::swbl_pwr_t  pwr;
  logic                 system_control_irq;
  int                   num_errors = 0;
  int                   n_compared = 0;
  int                   n_res = 0;
  int                   n_rst = 0;
  int                   r0;
  int                   r1;
  logic [31:0]          rd;
  logic [1:0]           rs;

  always #5 aclk = ~aclk;

  swbl_top #(.DEBOUNCE_CYC(4), .OVERRIDE_TICKS(8)) u_dut (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .pins, .pwr, .system_control_irq);

  swbl_far_model u_far (.aclk(aclk), .pins(pins));

  // Count wake pulses
  always @(negedge aclk) begin
    if (pwr.resume === 1'b1) n_res++;
    if (pwr.cpu_reset === 1'b1) n_rst++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bchk(input logic got, input logic exp);
    @(negedge aclk);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_awvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    rs = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    rd = s_axil_rdata;
    rs = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk(rd, exp);
  endtask

  task automatic wait_sleep(input logic v);
    int n;
    n = 0;
    while (pwr.asleep !== v && n < 300) begin
      @(negedge aclk);
      n++;
    end
    bchk(pwr.asleep, v);
  endtask

  task automatic endtest(input string name);
    $display("test %s done, errors so far %0d", name, num_errors);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("[ERR] %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ST, 32'h0);
    rchk(EN, 32'h0);
    rchk(STA, 32'h0);
    rchk(8'h20, 32'h0);
    chk({30'h0, rs}, {30'h0, swbl_pkg::RESP_SLVERR});
    axi_wr(8'h20, 32'h1f);
    chk({30'h0, rs}, {30'h0, swbl_pkg::RESP_SLVERR});
    endtest("reset");

    axi_wr(EN, 32'h2);
    fork
      u_far.press(1, 60);
    join_none
    repeat (15) @(posedge aclk);
    rchk(ST, 32'h2);
    bchk(system_control_irq, 1'b1);
    axi_wr(ST, 32'h0);
    rchk(ST, 32'h2);
    axi_wr(ST, 32'h2);
    repeat (70) @(posedge aclk);
    rchk(ST, 32'h0);
    bchk(system_control_irq, 1'b0);
    axi_wr(EN, 32'h1);
    u_far.press(0, 8);
    rchk(ST, 32'h1);
    bchk(system_control_irq, 1'b1);
    axi_wr(ST, 32'h1);
    axi_wr(EN, 32'h0);
    endtest("buttons_working");

    for (int k = 1; k <= 5; k++) begin
      r0 = n_res;
      r1 = n_rst;
      axi_wr(CTL, 32'h8 | k);
      wait_sleep(1'b1);
      chk({29'h0, pwr.kind}, 32'(k));
      rchk(STA, 32'h48 | k);
      u_far.press(0, 8);
      wait_sleep(1'b0);
      rchk(ST, 32'h5);
      chk(32'(n_res - r0), {31'h0, k == 1});
      chk(32'(n_rst - r1), {31'h0, k != 1});
      axi_wr(ST, 32'h1f);
    end
    endtest("sleep_kinds");

    axi_wr(CTL, 32'hb);
    wait_sleep(1'b1);
    u_far.press(1, 8);
    bchk(pwr.asleep, 1'b1);
    rchk(ST, 32'h2);
    axi_wr(EN, 32'h2);
    u_far.press(1, 8);
    wait_sleep(1'b0);
    rchk(ST, 32'h6);
    axi_wr(ST, 32'h1f);
    axi_wr(EN, 32'h4);
    endtest("sleep_button_wake");

    u_far.set_batt(1'b1);
    axi_wr(CTL, 32'ha);
    wait_sleep(1'b1);
    u_far.alarm_pulse();
    bchk(pwr.asleep, 1'b1);
    rchk(ST, 32'h8);
    axi_wr(ST, 32'h8);
    u_far.set_batt(1'b0);
    u_far.alarm_pulse();
    wait_sleep(1'b0);
    rchk(ST, 32'hc);
    axi_wr(ST, 32'h1f);
    axi_wr(CTL, 32'hc);
    wait_sleep(1'b1);
    u_far.alarm_pulse();
    bchk(pwr.asleep, 1'b1);
    axi_wr(ST, 32'h8);
    u_far.press(0, 8);
    wait_sleep(1'b0);
    axi_wr(ST, 32'h1f);
    axi_wr(EN, 32'h0);
    endtest("alarm");

    axi_wr(CTL, 32'h2);
    s_axil_wstrb <= 4'he;
    axi_wr(CTL, 32'hb);
    s_axil_wstrb <= 4'hf;
    rchk(CTL, 32'h2);
    axi_wr(CTL, 32'he);
    rchk(CTL, 32'h6);
    bchk(pwr.asleep, 1'b0);
    u_far.press(0, 16);
    u_far.press(0, 16);
    bchk(pwr.asleep, 1'b0);
    rchk(ST, 32'h1);
    axi_wr(ST, 32'h1);
    fork
      u_far.press(0, 80);
    join_none
    wait_sleep(1'b1);
    rchk(STA, 32'h4d);
    rchk(ST, 32'h10);
    repeat (100) @(posedge aclk);
    u_far.press(0, 8);
    wait_sleep(1'b0);
    endtest("override");
    wrap_up();
  end
endmodule
